// File: core/ddr_cmd_pkg.sv
package ddr_cmd_pkg;
  localparam int DDR_ROW_BITS = 13;
  localparam int DDR_ADDR_BITS = 13;
  localparam int DDR_BANKS = 4;
  localparam int DDR_PALL_BIT = 10;
  localparam int DDR_FIFO_DEPTH = 8;
  localparam logic [3:0] DDR_CMD_ACT = 4'h3;
  localparam logic [3:0] DDR_CMD_RD = 4'h5;
  localparam logic [3:0] DDR_CMD_WR = 4'h4;
  localparam logic [3:0] DDR_CMD_BST = 4'h6;
  localparam logic [3:0] DDR_CMD_PRE = 4'h2;
  localparam logic [3:0] DDR_CMD_REF = 4'h1;
  localparam logic [3:0] DDR_CMD_MRS = 4'h0;
  localparam logic [1:0] DDR_ORG_X4 = 2'h0;
  localparam logic [1:0] DDR_ORG_X8 = 2'h1;
  localparam logic [1:0] DDR_ORG_X16 = 2'h2;
  localparam logic [2:0] DDR_BL_2 = 3'h1;
  localparam logic [2:0] DDR_BL_4 = 3'h2;
  localparam logic [2:0] DDR_BL_8 = 3'h3;
  localparam logic [2:0] DDR_RL_2 = 3'h2;
  localparam logic [2:0] DDR_RL_25 = 3'h6;
  localparam logic [2:0] DDR_RL_3 = 3'h3;
  localparam logic [12:0] DDR_MODE_RST = 13'h0032;
  localparam logic [12:0] DDR_EMODE_RST = 13'h0000;
  typedef enum logic [4:0] {
    DDR_ST_IDLE = 5'b00001,
    DDR_ST_ACTIVE = 5'b00010,
    DDR_ST_PPD = 5'b00100,
    DDR_ST_APD = 5'b01000,
    DDR_ST_SREF = 5'b10000
  } ddr_pwr_e;
endpackage

// File: core/ddr_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module ddr_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 8
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_depthCheck
    $error("DEPTH must be a power of two");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wrPtr_ff;
  logic [AW:0] rdPtr_ff;
  logic full;
  assign full = (wrPtr_ff[AW] != rdPtr_ff[AW]) && (wrPtr_ff[AW-1:0] == rdPtr_ff[AW-1:0]);
  assign inReady = !full;
  assign outValid = wrPtr_ff != rdPtr_ff;
  assign outData = mem[rdPtr_ff[AW-1:0]];
  always_ff @(posedge sys_clk) begin
    if (inValid && !full) begin
      mem[wrPtr_ff[AW-1:0]] <= inData;
    end
  end
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wrPtr_ff <= '0;
      rdPtr_ff <= '0;
    end else begin
      if (inValid && !full) begin
        wrPtr_ff <= wrPtr_ff + 1'b1;
      end
      if (outValid && outReady) begin
        rdPtr_ff <= rdPtr_ff + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// File: core/ddr_cmd_if.sv
// What this block does
// - Register address and control on rising clock
// - Two data beats per clock, both edges
// - Clock enable high runs clocks and buffers
// - Enable low: precharge, active power-down, self-refresh
// - Output disable asynchronous; self-refresh exit at next rising clock
// - Buffers off in power-down and self refresh
// - Chip select high masks every command
// - Decode command from select and strobes
// - Write beats kept, mask bits stored with them
// - Lower mask low byte, upper mask high
// - Write mask ignored during reads
// - Bank select picks target bank
// - Bit 10 high precharges all banks
// - Row on activate, column plus auto-precharge
// - Mode load: opcode, bank picks register
// - Address widths per organization
// - Strobe out with reads, in with writes
// - Lower strobe low byte, upper high; here either input strobe captures both bytes
// - Burst length 2, 4, 8; order bit ignored
// - Read latency 2 or 3; 2.5 runs as 3
// - Bank select encodes banks A to D
// - Write mask has zero latency
`timescale 1ns/1ps
`default_nettype none
module ddr_cmd_if
  import ddr_cmd_pkg::*;
#(
  parameter logic [1:0] ORG = DDR_ORG_X16
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic clkEnable,
  input wire logic chipSelectN,
  input wire logic rowStrobeN,
  input wire logic colStrobeN,
  input wire logic writeEnableN,
  input wire logic bank_select_0,
  input wire logic bank_select_1,
  input wire logic [DDR_ADDR_BITS-1:0] addr,
  input wire logic [1:0] lower_write_mask,
  input wire logic [1:0] upper_write_mask,
  input wire logic [15:0] dataRiseIn,
  input wire logic [15:0] dataFallIn,
  input wire logic lower_data_strobe_in,
  input wire logic upper_data_strobe_in,
  output logic lower_data_strobe_out,
  output logic upper_data_strobe_out,
  output logic strobeOeN,
  output logic [15:0] dataRiseOut,
  output logic [15:0] dataFallOut,
  output logic dataOeN,
  input wire logic [31:0] readData,
  output logic readReq,
  output logic wrValid,
  input wire logic wrReady,
  output logic [35:0] wrWord,
  output logic [1:0] cmdBank,
  output logic [DDR_ROW_BITS-1:0] cmdRow,
  output logic [11:0] cmdCol,
  output logic cmdAutoPre,
  output logic [3:0] openBanks,
  output logic [4:0] powerState,
  output logic [12:0] modeReg,
  output logic [12:0] extModeReg,
  output logic refreshPulse
);
  if (ORG > DDR_ORG_X16) begin : g_orgCheck
    $error("ORG must be x4, x8 or x16");
  end

  typedef struct packed {
    ddr_pwr_e pwr;
    logic [3:0] open;
    logic [1:0] bank;
    logic [12:0] row;
    logic [11:0] col;
    logic autoPre;
    logic [12:0] mode;
    logic [12:0] emode;
    logic refresh;
    logic [3:0] rdWait;
    logic [3:0] rdLeft;
    logic [3:0] wrLeft;
    logic rdOn;
    logic [31:0] rdData;
    logic strobe;
  } ddr_state_s;

  ddr_state_s cur_ff;
  ddr_state_s nxt_cur;
  logic [3:0] cmd;
  logic active;
  logic fifoInValid;
  logic fifoInReady;
  logic [35:0] fifoIn;

  function automatic logic [3:0] burstBeats(input logic [2:0] bl);
    case (bl)
      DDR_BL_2: burstBeats = 4'h1;
      DDR_BL_4: burstBeats = 4'h2;
      DDR_BL_8: burstBeats = 4'h4;
      default: burstBeats = 4'h1;
    endcase
  endfunction

  // Output register adds the last clock, so count one short
  function automatic logic [3:0] latencyCycles(input logic [2:0] rl);
    case (rl)
      DDR_RL_2: latencyCycles = 4'h1;
      DDR_RL_25: latencyCycles = 4'h2;
      DDR_RL_3: latencyCycles = 4'h2;
      default: latencyCycles = 4'h2;
    endcase
  endfunction

  function automatic logic [11:0] colMask(input logic [12:0] a);
    case (ORG)
      DDR_ORG_X4: colMask = {1'b0, a[11], 10'h000} | {2'h0, a[9:0]};
      DDR_ORG_X8: colMask = {2'h0, a[9:0]};
      default: colMask = {3'h0, a[8:0]};
    endcase
  endfunction

  // Buffers off except clock enable in low-power states
  assign active = clkEnable && (cur_ff.pwr == DDR_ST_IDLE || cur_ff.pwr == DDR_ST_ACTIVE);
  assign cmd = chipSelectN ? 4'hF : {chipSelectN, rowStrobeN, colStrobeN, writeEnableN};

  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.refresh = 1'b0;
    nxt_cur.strobe = 1'b0;
    case (cur_ff.pwr)
      DDR_ST_IDLE, DDR_ST_ACTIVE: begin
        if (!clkEnable) begin
          if (cur_ff.open != 4'h0) begin
            nxt_cur.pwr = DDR_ST_APD;
          end else if (cmd == DDR_CMD_REF) begin
            nxt_cur.pwr = DDR_ST_SREF;
          end else begin
            nxt_cur.pwr = DDR_ST_PPD;
          end
        end else begin
          case (cmd)
            DDR_CMD_ACT: begin
              nxt_cur.bank = {bank_select_1, bank_select_0};
              nxt_cur.row = addr;
              nxt_cur.open[{bank_select_1, bank_select_0}] = 1'b1;
            end
            DDR_CMD_RD: begin
              nxt_cur.bank = {bank_select_1, bank_select_0};
              nxt_cur.col = colMask(addr);
              nxt_cur.autoPre = addr[DDR_PALL_BIT];
              nxt_cur.rdWait = latencyCycles(cur_ff.mode[6:4]);
              nxt_cur.rdLeft = burstBeats(cur_ff.mode[2:0]);
              nxt_cur.wrLeft = 4'h0;
            end
            DDR_CMD_WR: begin
              nxt_cur.bank = {bank_select_1, bank_select_0};
              nxt_cur.col = colMask(addr);
              nxt_cur.autoPre = addr[DDR_PALL_BIT];
              nxt_cur.wrLeft = burstBeats(cur_ff.mode[2:0]);
              nxt_cur.rdLeft = 4'h0;
              nxt_cur.rdOn = 1'b0;
            end
            DDR_CMD_BST: begin
              nxt_cur.rdLeft = 4'h0;
              nxt_cur.wrLeft = 4'h0;
              nxt_cur.rdOn = 1'b0;
            end
            DDR_CMD_PRE: begin
              if (addr[DDR_PALL_BIT]) begin
                nxt_cur.open = 4'h0;
              end else begin
                nxt_cur.open[{bank_select_1, bank_select_0}] = 1'b0;
              end
            end
            DDR_CMD_REF: nxt_cur.refresh = 1'b1;
            DDR_CMD_MRS: begin
              if (bank_select_0) begin
                nxt_cur.emode = addr;
              end else begin
                nxt_cur.mode = addr;
              end
            end
            default: ;
          endcase
          nxt_cur.pwr = (nxt_cur.open != 4'h0) ? DDR_ST_ACTIVE : DDR_ST_IDLE;
        end
      end
      DDR_ST_PPD, DDR_ST_APD: begin
        if (clkEnable) begin
          nxt_cur.pwr = (cur_ff.open != 4'h0) ? DDR_ST_ACTIVE : DDR_ST_IDLE;
        end
      end
      DDR_ST_SREF: begin
        // Exit taken at the next rising edge once enable is high
        if (clkEnable) begin
          nxt_cur.pwr = DDR_ST_IDLE;
        end
      end
      default: nxt_cur.pwr = DDR_ST_IDLE;
    endcase
    // Read pipeline: latency countdown then one word per clock
    if (cur_ff.rdWait != 4'h0) begin
      nxt_cur.rdWait = cur_ff.rdWait - 4'h1;
    end else if (cur_ff.rdLeft != 4'h0 && clkEnable) begin
      nxt_cur.rdLeft = cur_ff.rdLeft - 4'h1;
      nxt_cur.rdOn = 1'b1;
      nxt_cur.rdData = readData;
      nxt_cur.strobe = 1'b1;
    end else begin
      nxt_cur.rdOn = 1'b0;
    end
    if (cur_ff.wrLeft != 4'h0 && fifoInValid && fifoInReady) begin
      nxt_cur.wrLeft = cur_ff.wrLeft - 4'h1;
    end
    if (cur_ff.rdLeft == 4'h1 && cur_ff.rdWait == 4'h0 && clkEnable && cur_ff.autoPre) begin
      nxt_cur.open[cur_ff.bank] = 1'b0;
    end
    if (cur_ff.wrLeft == 4'h1 && fifoInValid && fifoInReady && cur_ff.autoPre) begin
      nxt_cur.open[cur_ff.bank] = 1'b0;
    end
    if (!active) begin
      nxt_cur.rdOn = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cur_ff <= '{pwr: DDR_ST_IDLE, mode: DDR_MODE_RST, emode: DDR_EMODE_RST, default: '0};
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // Write beats: rise and fall words taken together at the rising clock while either strobe is high, mask folded in at the same edge
  assign fifoInValid = (cur_ff.wrLeft != 4'h0) && active && (lower_data_strobe_in || upper_data_strobe_in);
  // Rise/fall mask bits per byte, no delay
  assign fifoIn = {upper_write_mask[1], lower_write_mask[1], upper_write_mask[0], lower_write_mask[0], dataFallIn, dataRiseIn};

  ddr_fifo #(.WIDTH(36), .DEPTH(DDR_FIFO_DEPTH)) u_wfifo (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .inValid(fifoInValid),
    .inReady(fifoInReady),
    .inData(fifoIn),
    .outValid(wrValid),
    .outReady(wrReady),
    .outData(wrWord)
  );

  // Mask pins never looked at while reading
  assign readReq = (cur_ff.rdWait == 4'h0) && (cur_ff.rdLeft != 4'h0) && clkEnable;
  assign dataRiseOut = cur_ff.rdData[15:0];
  assign dataFallOut = cur_ff.rdData[31:16];
  assign dataOeN = !(cur_ff.rdOn && clkEnable);
  assign strobeOeN = !(cur_ff.rdOn && clkEnable);
  assign lower_data_strobe_out = cur_ff.strobe;
  assign upper_data_strobe_out = cur_ff.strobe && (ORG == DDR_ORG_X16);
  assign cmdBank = cur_ff.bank;
  assign cmdRow = cur_ff.row;
  assign cmdCol = cur_ff.col;
  assign cmdAutoPre = cur_ff.autoPre;
  assign openBanks = cur_ff.open;
  assign powerState = cur_ff.pwr;
  assign modeReg = cur_ff.mode;
  assign extModeReg = cur_ff.emode;
  assign refreshPulse = cur_ff.refresh;
endmodule
`default_nettype wire

// File: test/ddr_cmd_if_sva.sv
`timescale 1ns/1ps
`default_nettype none
module ddr_cmd_if_sva
  import ddr_cmd_pkg::*;
#(
  parameter logic [1:0] ORG = DDR_ORG_X16
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic clkEnable,
  input wire logic chipSelectN,
  input wire logic rowStrobeN,
  input wire logic colStrobeN,
  input wire logic writeEnableN,
  input wire logic bank_select_0,
  input wire logic bank_select_1,
  input wire logic [DDR_ADDR_BITS-1:0] addr,
  input wire logic lower_data_strobe_out,
  input wire logic upper_data_strobe_out,
  input wire logic strobeOeN,
  input wire logic dataOeN,
  input wire logic [DDR_ROW_BITS-1:0] cmdRow,
  input wire logic [3:0] openBanks,
  input wire logic [4:0] powerState,
  input wire logic [12:0] modeReg,
  input wire logic refreshPulse
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  wire logic [3:0] cmd = {chipSelectN, rowStrobeN, colStrobeN, writeEnableN};
  wire logic [1:0] bank = {bank_select_1, bank_select_0};
  wire logic live = clkEnable && (powerState == 5'h01 || powerState == 5'h02);
  sequence s_take(logic [3:0] c); live && cmd == c; endsequence
  sequence s_apd; powerState == 5'h02 && !clkEnable; endsequence
  sequence s_apd_wake; powerState == 5'h08 && clkEnable; endsequence
  property p_act; s_take(DDR_CMD_ACT) |=> openBanks[$past(bank)] && cmdRow == $past(addr); endproperty
  a_act: assert property (p_act) else $error("row not opened");
  property p_cs; chipSelectN |=> !refreshPulse && $stable(modeReg); endproperty
  a_cs: assert property (p_cs) else $error("deselected command acted");
  property p_pre; s_take(DDR_CMD_PRE) ##0 addr[DDR_PALL_BIT] |=> openBanks == 4'h0; endproperty
  a_pre: assert property (p_pre) else $error("banks left open");
  property p_mrs; s_take(DDR_CMD_MRS) ##0 !bank_select_0 |=> modeReg == $past(addr); endproperty
  a_mrs: assert property (p_mrs) else $error("mode not loaded");
  property p_ref; s_take(DDR_CMD_REF) |=> refreshPulse; endproperty
  a_ref: assert property (p_ref) else $error("refresh missed");
  property p_oe; !clkEnable |-> dataOeN && strobeOeN; endproperty
  a_oe: assert property (p_oe) else $error("drivers on while disabled");
  property p_stb;
    lower_data_strobe_out |-> (upper_data_strobe_out == (ORG == DDR_ORG_X16)) &&
      !dataOeN && !strobeOeN;
  endproperty
  a_stb: assert property (p_stb) else $error("strobe without drive");
  property p_apd_in; s_apd |=> powerState == 5'h08; endproperty
  a_apd_in: assert property (p_apd_in) else $error("no active power-down");
  property p_apd_out; s_apd_wake |=> powerState == 5'h02; endproperty
  a_apd_out: assert property (p_apd_out) else $error("no power-down exit");
  property p_sref;
    !clkEnable && powerState == 5'h01 && cmd == DDR_CMD_REF |=> powerState == 5'h10;
  endproperty
  a_sref: assert property (p_sref) else $error("no self refresh");
endmodule
bind ddr_cmd_if ddr_cmd_if_sva #(.ORG(ORG)) u_sva (.*);
`default_nettype wire

// File: test/ddr_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module ddr_ctrl_model
  import ddr_cmd_pkg::*;
(
  input wire logic sys_clk,
  output logic clkEnable,
  output logic [3:0] cmdLines,
  output logic [1:0] bankSel,
  output logic [12:0] addr,
  output logic [1:0] lowMask,
  output logic [1:0] upMask,
  output logic [15:0] rise,
  output logic [15:0] fall,
  output logic strobe
);
  initial begin
    clkEnable = 1'b1;
    cmdLines = 4'hF;
    {bankSel, addr, lowMask, upMask, rise, fall, strobe} = '0;
  end
  // Caller opens rows before access and paces refresh
  task automatic issue(input logic [3:0] c, input logic [1:0] b, input logic [12:0] a,
      input logic ce);
    @(negedge sys_clk);
    cmdLines = c;
    bankSel = b;
    addr = a;
    clkEnable = ce; // Held high during accesses
    @(negedge sys_clk);
    cmdLines = 4'h7;
    addr = ~a;
    if (c == DDR_CMD_MRS) repeat (2) @(negedge sys_clk);
  endtask
  task automatic put(input int n, input logic [15:0] base);
    for (int i = 0; i < n; i++) begin
      rise = base + 16'(i);
      fall = ~rise;
      lowMask = rise[1:0];
      upMask = rise[3:2];
      strobe = 1'b1; // One word per strobe cycle
      @(negedge sys_clk);
    end
    strobe = 1'b0;
    rise = ~rise;
    fall = ~fall;
  endtask
endmodule
`default_nettype wire

// File: test/ddr_cmd_if_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module ddr_cmd_if_tb_top;
  import ddr_cmd_pkg::*;
  logic sys_clk, resetn, clkEnable, chipSelectN, rowStrobeN, colStrobeN, writeEnableN;
  logic bank_select_0, bank_select_1, lower_data_strobe_in, upper_data_strobe_in, wrReady;
  logic lower_data_strobe_out, upper_data_strobe_out, strobeOeN, dataOeN, readReq, wrValid;
  logic cmdAutoPre, refreshPulse;
  logic [12:0] addr, cmdRow, modeReg, extModeReg, r;
  logic [1:0] lower_write_mask, upper_write_mask, cmdBank;
  logic [15:0] dataRiseIn, dataFallIn, dataRiseOut, dataFallOut, rdCnt, base;
  logic [15:0] rdSeed;
  logic [31:0] readData;
  logic [35:0] wrWord;
  logic [11:0] cmdCol;
  logic [3:0] openBanks, cmdLines;
  logic [4:0] powerState;
  logic [2:0] bls [3] = '{DDR_BL_2, DDR_BL_4, DDR_BL_8};
  logic [2:0] lats [3] = '{DDR_RL_2, DDR_RL_25, DDR_RL_3};
  int num_errors = 0;
  int n_checks = 0;
  int seed = 32'h76d1900f;
  assign {chipSelectN, rowStrobeN, colStrobeN, writeEnableN} = cmdLines;
  assign upper_data_strobe_in = lower_data_strobe_in;
  assign readData = {~rdCnt, rdCnt};
  ddr_cmd_if #(.ORG(DDR_ORG_X16)) uut (.*);
  ddr_ctrl_model ctl (.sys_clk, .clkEnable, .cmdLines, .bankSel({bank_select_1, bank_select_0}),
    .addr, .lowMask(lower_write_mask), .upMask(upper_write_mask), .rise(dataRiseIn),
    .fall(dataFallIn), .strobe(lower_data_strobe_in));
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    if (!resetn) begin
      rdCnt <= rdSeed;
    end else if (readReq) begin
      rdCnt <= rdCnt + 16'h0001;
    end
  end
  function automatic logic [35:0] expWord(input logic [15:0] v);
    return {v[3], v[1], v[2], v[0], ~v, v};
  endfunction
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    $display("Checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic rdRun(input logic [2:0] bl, input logic [2:0] lat);
    logic [12:0] a;
    logic [15:0] e;
    int n, w;
    a = 13'($random(seed));
    ctl.issue(DDR_CMD_MRS, 2'h0, {6'h00, lat, 1'b0, bl}, 1'b1);
    chk(40'(modeReg), 40'({6'h00, lat, 1'b0, bl}));
    ctl.issue(DDR_CMD_ACT, 2'h0, a, 1'b1);
    e = rdCnt;
    ctl.issue(DDR_CMD_RD, 2'h0, a, 1'b1);
    chk(40'({cmdAutoPre, cmdCol}), 40'({a[10], 3'h0, a[8:0]}));
    n = 1;
    w = 0;
    repeat (12) begin
      chk(40'(dataOeN), 40'(!lower_data_strobe_out));
      if (lower_data_strobe_out === 1'b1) begin
        if (w == 0) chk(40'(n), 40'((lat == DDR_RL_2) ? 3 : 4));
        chk(40'({dataFallOut, dataRiseOut}), 40'({~e, e}));
        e++;
        w++;
      end
      @(negedge sys_clk);
      n++;
    end
    chk(40'(w), 40'(1 << (bl - 3'h1)));
    ctl.issue(DDR_CMD_PRE, 2'h0, 13'h0400, 1'b1);
  endtask
  initial begin
    resetn = 1'b0;
    wrReady = 1'b0;
    rdSeed = 16'($random(seed));
    repeat (4) @(negedge sys_clk);
    resetn = 1'b1;
    chk(40'({modeReg, powerState, dataOeN, openBanks}), 40'({DDR_MODE_RST, 10'h030}));
    ctl.issue(4'hB, 2'h1, 13'h0005, 1'b1);
    chk(40'(openBanks), 40'(0));
    for (int b = 0; b < 4; b++) begin
      r = 13'($random(seed));
      ctl.issue(DDR_CMD_ACT, 2'(b), r, 1'b1);
      chk(40'({cmdBank, cmdRow, openBanks[b]}), 40'({2'(b), r, 1'b1}));
    end
    ctl.issue(DDR_CMD_BST, 2'h0, 13'h0000, 1'b1);
    ctl.issue(DDR_CMD_PRE, 2'h2, 13'h0000, 1'b1);
    chk(40'(openBanks), 40'(4'hB));
    ctl.issue(4'h7, 2'h0, 13'h0000, 1'b0);
    chk(40'({powerState, dataOeN}), 40'({5'h08, 1'b1}));
    ctl.issue(4'h7, 2'h0, 13'h0000, 1'b1);
    chk(40'(powerState), 40'(5'h02));
    ctl.issue(DDR_CMD_PRE, 2'h1, 13'h0400, 1'b1);
    ctl.issue(4'h7, 2'h0, 13'h0000, 1'b0);
    chk(40'({openBanks, powerState}), 40'(5'h04));
    ctl.issue(4'h7, 2'h0, 13'h0000, 1'b1);
    chk(40'(powerState), 40'(5'h01));
    ctl.issue(DDR_CMD_REF, 2'h0, 13'h0000, 1'b1);
    chk(40'({powerState, refreshPulse}), 40'(6'h03));
    ctl.issue(DDR_CMD_REF, 2'h0, 13'h0000, 1'b0);
    chk(40'(powerState), 40'(5'h10));
    ctl.issue(4'h7, 2'h0, 13'h0000, 1'b1);
    ctl.issue(DDR_CMD_MRS, 2'h1, r, 1'b1);
    chk(40'({powerState, extModeReg}), 40'({5'h01, r}));
    foreach (lats[i]) foreach (bls[j]) rdRun(bls[j], lats[i]);
    base = 16'($random(seed));
    ctl.issue(DDR_CMD_ACT, 2'h1, 13'h0001, 1'b1);
    for (int i = 0; i < 3; i++) begin
      ctl.issue(DDR_CMD_WR, 2'h1, 13'h0000, 1'b1);
      ctl.put(4, base + 16'(4 * i));
    end
    for (int i = 0; i < 8; i++) begin
      chk(40'({wrValid, wrWord}), 40'({1'b1, expWord(base + 16'(i))}));
      wrReady = 1'b1;
      @(negedge sys_clk);
    end
    chk(40'(wrValid), 40'(0));
    test_done();
  end
  initial begin
    #100000;
    num_errors++;
    test_done();
  end
endmodule
`default_nettype wire
